// ### hw/dma_ctrl_cfg.svh
// Offsets, field positions, reset values and timing counts of the DMA control bank.
`ifndef DMA_CTRL_CFG_SVH
`define DMA_CTRL_CFG_SVH

// ==================================================================
// Register indices (printed offsets); byte address is index times four
`define IDX_GLOBAL_COMMAND     8'h00
`define IDX_TEST_FUNCTION      8'h02
`define IDX_CLOCK_LOCK_STATUS  8'h03
`define IDX_CONFIG_ORIGIN_CODE 8'h05
`define IDX_WORD_ORDER_CONFIG  8'h0F
`define IDX_PORT_PATH_ENABLE   8'h10
`define IDX_UNDERFLOW_FLAGS    8'h18
`define IDX_OVERFLOW_FLAGS     8'h1A
`define IDX_LEGACY_DATA_PATH   8'h40
`define IDX_LEGACY_DIRECTION   8'h41
`define IDX_LEGACY_EDGE        8'h42
`define IDX_LEGACY_FRAMING     8'h43
`define IDX_IRQ_STATUS         8'h44
`define IDX_IRQ_MASK           8'h45

// ==================================================================
// Field positions
`define BIT_COMMAND_ENABLE     3
`define BIT_HALF_WORD_EXCHANGE 3
`define BIT_BYTE_PAIR_EXCHANGE 0

// ==================================================================
// Reset values and codes
`define RST_BYTE               8'h00
`define ORIGIN_CODE_DEFAULT    8'h5A
`define AXI_RESP_OKAY          2'h0
`define AXI_RESP_SLVERR        2'h2

// ==================================================================
// Transfer-clock loop lock time in cycles after release from reset
`define LOCK_DELAY_CYCLES      8'h10

`endif

// ### hw/dma_ctrl_pkg.sv
// Types shared by the DMA control register bank.
package dma_ctrl_pkg;

    // ==================================================================
    // Bus slave states, Gray coded along the write path only.
    typedef enum logic [1:0] {
        BUS_IDLE  = 2'b00,
        BUS_WRESP = 2'b01,
        BUS_RDATA = 2'b11
    } bus_state_t;

    // Software-visible control registers.
    typedef struct packed {
        logic [7:0]  global_command;
        logic [7:0]  test_function;
        logic [7:0]  word_order_config;
        logic [15:0] port_path_enable;
        logic [7:0]  legacy_data_path;
        logic [7:0]  legacy_direction;
        logic [7:0]  legacy_edge;
        logic [3:0]  irq_mask;
    } ctrl_regs_t;

endpackage : dma_ctrl_pkg

// ### hw/dma_channel_control_regs.sv
// AXI4-Lite control and status bank steering DMA channels and word ordering.
//
// What this block does
// - Command enable activates channels selected in enable register.
// - Command enable clear resets channels, flushes, clears flags.
// - Status bit 0 shows transfer clock locked.
// - Both ports disabled resets transfer clock loop.
// - Read-only byte gives configuration origin code.
// - Config bit 3 exchanges the 16-bit halves.
// - Config bit 0 swaps byte pairs: 1,0,3,2.
// - Both swaps give fully reversed bytes 3,2,1,0.
// - Unswapped word: byte 0 lowest, byte 3 highest.
// - Enable bits 3,2 run transmit ports 1,0.
// - Enable bits 1,0 run receive ports 1,0.
// - Legacy path, direction, edge, framing registers exist.
// - Transmit underflow sets flag, repeats last byte.
// - Receive overflow sets flag, discards until re-enable.
`timescale 1ns/10ps
`include "dma_ctrl_cfg.svh"

module dma_channel_control_regs
    import dma_ctrl_pkg::*;
#(
    parameter logic [7:0] ORIGIN_CODE = `ORIGIN_CODE_DEFAULT // Arbitrary value.
) (
    input  wire  logic        clk,            // 20 MHz clock.
    input  wire  logic        rst_n,          // Asynchronous active-low reset.
    input  wire  logic [9:0]  s_axi_awaddr,   // Write address.
    input  wire  logic        s_axi_awvalid,  // Write address valid.
    output logic              s_axi_awready,  // Write address ready.
    input  wire  logic [31:0] s_axi_wdata,    // Write data.
    input  wire  logic [3:0]  s_axi_wstrb,    // Write byte strobes.
    input  wire  logic        s_axi_wvalid,   // Write data valid.
    output logic              s_axi_wready,   // Write data ready.
    output logic [1:0]        s_axi_bresp,    // Write response.
    output logic              s_axi_bvalid,   // Write response valid.
    input  wire  logic        s_axi_bready,   // Write response ready.
    input  wire  logic [9:0]  s_axi_araddr,   // Read address.
    input  wire  logic        s_axi_arvalid,  // Read address valid.
    output logic              s_axi_arready,  // Read address ready.
    output logic [31:0]       s_axi_rdata,    // Read data.
    output logic [1:0]        s_axi_rresp,    // Read response.
    output logic              s_axi_rvalid,   // Read data valid.
    input  wire  logic        s_axi_rready,   // Read data ready.
    input  wire  logic [1:0]  tx_in_valid,    // DMA word offered per transmit port.
    input  wire  logic [63:0] tx_in_word,     // DMA words, port 1 high.
    input  wire  logic [1:0]  tx_fifo_empty,  // Transmit FIFO empty per port.
    input  wire  logic [1:0]  tx_byte_take,   // Port takes a transmit byte.
    input  wire  logic [1:0]  tx_byte_new,    // New transmit byte from FIFO.
    input  wire  logic [15:0] tx_byte_in,     // Transmit bytes from FIFOs.
    input  wire  logic [1:0]  rx_in_valid,    // Receive word from port.
    input  wire  logic [63:0] rx_in_word,     // Receive words, port 1 high.
    input  wire  logic [1:0]  rx_fifo_full,   // Receive FIFO full per port.
    input  wire  logic [7:0]  legacy_framing, // Legacy framing status input.
    output logic [1:0]        tx_out_valid,   // Reordered transmit word valid.
    output logic [63:0]       tx_out_word,    // Reordered transmit words.
    output logic [15:0]       tx_line_byte,   // Byte sent on each port.
    output logic [1:0]        rx_out_valid,   // Reordered receive word valid.
    output logic [63:0]       rx_out_word,    // Reordered receive words.
    output logic [3:0]        chan_reset,     // Channel reset, rx0,rx1,tx0,tx1 low.
    output logic              fifo_flush,     // Flush all channel FIFOs.
    output logic              pll_reset,      // Transfer clock loop reset.
    output logic              irq             // Level interrupt.
);

    // ==================================================================
    // State

    typedef struct packed {
        logic [1:0]  rst_sync;
        bus_state_t  bus;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic [1:0]  bresp;
        logic        aw_held;
        logic        w_held;
        logic [7:0]  aw_idx;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        ctrl_regs_t  regs;
        logic [1:0]  underflow;
        logic [1:0]  overflow;
        logic [3:0]  irq_status;
        logic [7:0]  lock_count;
        logic        locked;
        logic [1:0]  tx_valid;
        logic [63:0] tx_word;
        logic [15:0] tx_byte;
        logic [1:0]  rx_valid;
        logic [63:0] rx_word;
        logic [3:0]  chan_rst;
        logic        flush;
        logic        pll_rst;
        logic        irq;
    } state_t;

    state_t      cur;
    state_t      next_cur;
    logic        rst_local_n;

    assign rst_local_n = cur.rst_sync[1];

    // Reorders a word per the half-word and byte-pair controls.
    function automatic logic [31:0] reorder(input logic [31:0] w, input logic hx,
                                            input logic bx);
        logic [31:0] t;
        t = hx ? {w[15:0], w[31:16]} : w;
        if (bx) begin
            t = {t[23:16], t[31:24], t[7:0], t[15:8]};
        end
        return t;
    endfunction : reorder

    // Places a narrow value into the low bits of a read word.
    function automatic logic [31:0] rd8(input logic [7:0] v);
        return {24'h000000, v};
    endfunction : rd8

    // ==================================================================
    // Next-state logic.
    always_comb begin
        logic        run;
        logic [1:0]  tx_en;
        logic [1:0]  rx_en;
        logic        wr_fire;
        logic        rd_fire;
        logic [7:0]  ridx;
        logic [31:0] wd;
        logic [1:0]  new_under;
        logic [1:0]  new_over;
        logic        rd_status;
        run       = 1'b0;
        tx_en     = 2'b00;
        rx_en     = 2'b00;
        wr_fire   = 1'b0;
        rd_fire   = 1'b0;
        ridx      = s_axi_araddr[9:2];
        wd        = 32'h00000000;
        new_under = 2'b00;
        new_over  = 2'b00;
        rd_status = 1'b0;
        next_cur  = cur;
        next_cur.rst_sync = {cur.rst_sync[0], 1'b1};

        // Channel enables gated by the global command bit.
        run   = cur.regs.global_command[`BIT_COMMAND_ENABLE];
        tx_en = cur.regs.port_path_enable[3:2] & {2{run}};
        rx_en = cur.regs.port_path_enable[1:0] & {2{run}};
        next_cur.chan_rst = ~{tx_en, rx_en};
        next_cur.flush    = ~run;

        // Loop reset while no port has any path enabled.
        next_cur.pll_rst = (cur.regs.port_path_enable[3:0] == 4'h0);
        if (cur.pll_rst) begin
            next_cur.lock_count = `RST_BYTE;
            next_cur.locked     = 1'b0;
        end else if (cur.lock_count != `LOCK_DELAY_CYCLES) begin
            next_cur.lock_count = cur.lock_count + 8'h01;
        end else begin
            next_cur.locked = 1'b1;
        end

        // Transmit words reordered; underflow repeats the last byte.
        for (int p = 0; p < 2; p++) begin
            next_cur.tx_valid[p] = tx_in_valid[p] & tx_en[p];
            next_cur.tx_word[p*32 +: 32] = reorder(tx_in_word[p*32 +: 32],
                cur.regs.word_order_config[`BIT_HALF_WORD_EXCHANGE],
                cur.regs.word_order_config[`BIT_BYTE_PAIR_EXCHANGE]);
            if (!tx_en[p]) begin
                next_cur.tx_byte[p*8 +: 8] = 8'h00;
            end else if (tx_byte_new[p]) begin
                next_cur.tx_byte[p*8 +: 8] = tx_byte_in[p*8 +: 8];
            end
            new_under[p] = tx_en[p] & tx_byte_take[p] & tx_fifo_empty[p];
            new_over[p]  = rx_en[p] & rx_in_valid[p] & rx_fifo_full[p];
            next_cur.rx_valid[p] = rx_in_valid[p] & rx_en[p] & ~rx_fifo_full[p]
                                   & ~cur.overflow[p];
            next_cur.rx_word[p*32 +: 32] = reorder(rx_in_word[p*32 +: 32],
                cur.regs.word_order_config[`BIT_HALF_WORD_EXCHANGE],
                cur.regs.word_order_config[`BIT_BYTE_PAIR_EXCHANGE]);
        end
        // Flags cleared only by disabling the channel.
        next_cur.underflow = (cur.underflow | new_under) & tx_en;
        next_cur.overflow  = (cur.overflow | new_over) & rx_en;

        // Write address and data taken in either order.
        if (s_axi_awvalid && !cur.aw_held && cur.bus == BUS_IDLE) begin
            next_cur.aw_held = 1'b1;
            next_cur.aw_idx  = s_axi_awaddr[9:2];
        end
        if (s_axi_wvalid && !cur.w_held && cur.bus == BUS_IDLE) begin
            next_cur.w_held = 1'b1;
            next_cur.w_data = s_axi_wdata;
            next_cur.w_strb = s_axi_wstrb;
        end
        wr_fire = cur.aw_held & cur.w_held & (cur.bus == BUS_IDLE);
        rd_fire = s_axi_arvalid & (cur.bus == BUS_IDLE) & ~wr_fire;
        wd = cur.w_data;

        // Register writes; unused bits are masked off.
        if (wr_fire) begin
            next_cur.aw_held = 1'b0;
            next_cur.w_held  = 1'b0;
            next_cur.bus     = BUS_WRESP;
            next_cur.bresp   = `AXI_RESP_OKAY;
            case (cur.aw_idx)
                `IDX_GLOBAL_COMMAND: begin
                    if (cur.w_strb[0]) next_cur.regs.global_command = wd[7:0] & 8'h08;
                end
                `IDX_TEST_FUNCTION: begin
                    if (cur.w_strb[0]) next_cur.regs.test_function = wd[7:0] & 8'h01;
                end
                `IDX_WORD_ORDER_CONFIG: begin
                    if (cur.w_strb[0]) next_cur.regs.word_order_config = wd[7:0] & 8'h09;
                end
                `IDX_PORT_PATH_ENABLE: begin
                    if (cur.w_strb[0]) next_cur.regs.port_path_enable = {8'h00, wd[7:0] & 8'h0F};
                end
                `IDX_LEGACY_DATA_PATH: begin
                    if (cur.w_strb[0]) next_cur.regs.legacy_data_path = wd[7:0];
                end
                `IDX_LEGACY_DIRECTION: begin
                    if (cur.w_strb[0]) next_cur.regs.legacy_direction = wd[7:0];
                end
                `IDX_LEGACY_EDGE: begin
                    if (cur.w_strb[0]) next_cur.regs.legacy_edge = wd[7:0];
                end
                `IDX_IRQ_MASK: begin
                    if (cur.w_strb[0]) next_cur.regs.irq_mask = wd[3:0];
                end
                `IDX_CLOCK_LOCK_STATUS, `IDX_CONFIG_ORIGIN_CODE, `IDX_UNDERFLOW_FLAGS,
                `IDX_OVERFLOW_FLAGS, `IDX_LEGACY_FRAMING, `IDX_IRQ_STATUS: begin
                    next_cur.bresp = `AXI_RESP_OKAY;
                end
                default: begin
                    next_cur.bresp = `AXI_RESP_SLVERR;
                end
            endcase
        end

        // Register reads.
        if (rd_fire) begin
            next_cur.bus   = BUS_RDATA;
            next_cur.rresp = `AXI_RESP_OKAY;
            case (ridx)
                `IDX_GLOBAL_COMMAND:     next_cur.rdata = rd8(cur.regs.global_command);
                `IDX_TEST_FUNCTION:      next_cur.rdata = rd8(cur.regs.test_function);
                `IDX_CLOCK_LOCK_STATUS:  next_cur.rdata = rd8({7'h00, cur.locked});
                `IDX_CONFIG_ORIGIN_CODE: next_cur.rdata = rd8(ORIGIN_CODE);
                `IDX_WORD_ORDER_CONFIG:  next_cur.rdata = rd8(cur.regs.word_order_config);
                `IDX_PORT_PATH_ENABLE:   next_cur.rdata = {16'h0000, cur.regs.port_path_enable};
                `IDX_UNDERFLOW_FLAGS:    next_cur.rdata = rd8({6'h00, cur.underflow});
                `IDX_OVERFLOW_FLAGS:     next_cur.rdata = rd8({6'h00, cur.overflow});
                `IDX_LEGACY_DATA_PATH:   next_cur.rdata = rd8(cur.regs.legacy_data_path);
                `IDX_LEGACY_DIRECTION:   next_cur.rdata = rd8(cur.regs.legacy_direction);
                `IDX_LEGACY_EDGE:        next_cur.rdata = rd8(cur.regs.legacy_edge);
                `IDX_LEGACY_FRAMING:     next_cur.rdata = rd8(legacy_framing);
                `IDX_IRQ_STATUS: begin
                    next_cur.rdata = rd8({4'h0, cur.irq_status});
                    rd_status      = 1'b1;
                end
                `IDX_IRQ_MASK:           next_cur.rdata = rd8({4'h0, cur.regs.irq_mask});
                default: begin
                    next_cur.rdata = 32'h00000000;
                    next_cur.rresp = `AXI_RESP_SLVERR;
                end
            endcase
        end

        // Sticky events: underflow 1..0, overflow 3..2; a new event beats the read clear.
        next_cur.irq_status = (rd_status ? 4'h0 : cur.irq_status)
                              | {new_over, new_under};
        next_cur.irq = |(next_cur.irq_status & cur.regs.irq_mask);

        // Response handshakes.
        if (cur.bus == BUS_WRESP && s_axi_bready) begin
            next_cur.bus = BUS_IDLE;
        end
        if (cur.bus == BUS_RDATA && s_axi_rready) begin
            next_cur.bus = BUS_IDLE;
        end
    end

    // ==================================================================
    // State register with asynchronous reset.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur          <= '0;
            cur.chan_rst <= 4'hF;
            cur.flush    <= 1'b1;
            cur.pll_rst  <= 1'b1;
        end else if (!rst_local_n) begin
            cur          <= '0;
            cur.rst_sync <= {cur.rst_sync[0], 1'b1};
            cur.chan_rst <= 4'hF;
            cur.flush    <= 1'b1;
            cur.pll_rst  <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    // ==================================================================
    // Outputs from the state register; the bus ready and valid flags are decoded from it.
    assign s_axi_awready = ~cur.aw_held & (cur.bus == BUS_IDLE) & rst_local_n;
    assign s_axi_wready  = ~cur.w_held & (cur.bus == BUS_IDLE) & rst_local_n;
    assign s_axi_bvalid  = (cur.bus == BUS_WRESP);
    assign s_axi_bresp   = cur.bresp;
    assign s_axi_arready = (cur.bus == BUS_IDLE) & ~(cur.aw_held & cur.w_held) & rst_local_n;
    assign s_axi_rvalid  = (cur.bus == BUS_RDATA);
    assign s_axi_rdata   = cur.rdata;
    assign s_axi_rresp   = cur.rresp;
    assign tx_out_valid  = cur.tx_valid;
    assign tx_out_word   = cur.tx_word;
    assign tx_line_byte  = cur.tx_byte;
    assign rx_out_valid  = cur.rx_valid;
    assign rx_out_word   = cur.rx_word;
    assign chan_reset    = cur.chan_rst;
    assign fifo_flush    = cur.flush;
    assign pll_reset     = cur.pll_rst;
    assign irq           = cur.irq;

endmodule : dma_channel_control_regs

// ### test/dma_ctrl_assertions.sv
// Port-level checks of the DMA control bank.
`timescale 1ns/10ps
module dma_ctrl_checker (
    input wire logic        clk,          // Clock.
    input wire logic        rst_n,        // Reset.
    input wire logic [1:0]  s_axi_bresp,  // Write response.
    input wire logic        s_axi_bvalid, // Response valid.
    input wire logic        s_axi_bready, // Response ready.
    input wire logic        s_axi_arvalid,// Read address valid.
    input wire logic        s_axi_arready,// Read address ready.
    input wire logic        s_axi_rvalid, // Read data valid.
    input wire logic [1:0]  tx_in_valid,  // Words in.
    input wire logic [63:0] tx_in_word,   // Words in.
    input wire logic [1:0]  tx_byte_new,  // Fresh byte.
    input wire logic [1:0]  rx_in_valid,  // Receive in.
    input wire logic [1:0]  rx_fifo_full, // Receive full.
    input wire logic [1:0]  tx_out_valid, // Words out.
    input wire logic [63:0] tx_out_word,  // Words out.
    input wire logic [15:0] tx_line_byte, // Line bytes.
    input wire logic [1:0]  rx_out_valid, // Receive out.
    input wire logic [3:0]  chan_reset,   // Channel resets.
    input wire logic        fifo_flush,   // Flush.
    input wire logic        pll_reset,    // Loop reset.
    input wire logic        irq           // Interrupt.
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // True when a word is one of the four legal byte orders of another.
    function automatic bit legal(input logic [31:0] o, input logic [31:0] i);
        return o == i || o == {i[15:0], i[31:16]} || o == {i[23:16], i[31:24], i[7:0], i[15:8]}
            || o == {i[7:0], i[15:8], i[23:16], i[31:24]};
    endfunction : legal

    // Checks on channel control, data order and bus handshakes.
    AST_FLUSH_RESETS: assert property (fifo_flush |-> chan_reset == 4'hF)
        else $error("flush with a channel live");
    AST_LOOP_RESET: assert property (pll_reset |-> chan_reset == 4'hF)
        else $error("loop reset with a path live");
    AST_TX_ORDER: assert property (tx_out_valid[0] |->
        legal(tx_out_word[31:0], $past(tx_in_word[31:0])))
        else $error("bad transmit reorder");
    AST_TX_VALID: assert property (tx_out_valid != 2'b00 |->
        (tx_out_valid & ~$past(tx_in_valid)) == 2'b00)
        else $error("transmit word unasked");
    AST_RX_DROP: assert property (rx_out_valid != 2'b00 |->
        (rx_out_valid & ~$past(rx_in_valid & ~rx_fifo_full)) == 2'b00)
        else $error("receive word into full fifo");
    AST_LINE_HOLD: assert property (!chan_reset[2] && $past(!chan_reset[2] && !tx_byte_new[0])
        |-> tx_line_byte[7:0] == $past(tx_line_byte[7:0]))
        else $error("line byte changed");
    AST_BRESP_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");

    // Main scenarios reached.
    COV_IRQ: cover property ($rose(irq));
    COV_OVERFLOW: cover property ((rx_in_valid & rx_fifo_full) != 2'b00);
    COV_LOOP: cover property ($fell(pll_reset));
endmodule : dma_ctrl_checker

// ### test/dma_far_side.sv
// Behavioural model of the DMA channel FIFOs and port logic.
`timescale 1ns/10ps
module dma_far_side #(
    parameter logic [7:0] FRAMING = 8'h3C // Framing status shown.
) (
    input  wire logic        clk,           // Clock.
    input  wire logic        underrun,      // Starve transmit FIFOs.
    input  wire logic        overrun,       // Fill receive FIFOs.
    output logic [1:0]       tx_fifo_empty, // Transmit FIFO empty.
    output logic [1:0]       tx_byte_take,  // Port takes a byte.
    output logic [1:0]       tx_byte_new,   // Fresh byte offered.
    output logic [15:0]      tx_byte_in,    // Bytes offered.
    output logic [1:0]       rx_fifo_full,  // Receive FIFO full.
    output logic [7:0]       legacy_framing // Framing status.
);
    logic [31:0] r;

    // FIFO flags follow the stall requests.
    assign tx_fifo_empty  = {2{underrun}};
    assign rx_fifo_full   = {2{overrun}};
    assign legacy_framing = FRAMING;
    initial {tx_byte_take, tx_byte_new, tx_byte_in} = '0;

    // Ports take at random, and on every edge while starved; a starved FIFO offers only stale, flipping bytes.
    always @(posedge clk) begin
        r = $urandom;
        tx_byte_take <= r[1:0] | {2{underrun}};
        tx_byte_new  <= underrun ? 2'b00 : r[1:0];
        tx_byte_in   <= underrun ? ~tx_byte_in : r[31:16];
    end
endmodule : dma_far_side

// ### test/tb_top.sv
// Self-checking bench of the DMA control register bank.
`timescale 1ns/10ps
`include "dma_ctrl_cfg.svh"
module tb_top;
    logic        clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, fifo_flush, pll_reset, irq, underrun, overrun;
    logic [9:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb, chan_reset;
    logic [1:0]  s_axi_bresp, s_axi_rresp, tx_in_valid, tx_fifo_empty, tx_byte_take;
    logic [1:0]  tx_byte_new, rx_in_valid, rx_fifo_full, tx_out_valid, rx_out_valid;
    logic [63:0] tx_in_word, rx_in_word, tx_out_word, rx_out_word;
    logic [15:0] tx_byte_in, tx_line_byte;
    logic [7:0]  legacy_framing;
    logic [33:0] rq[$];
    logic [129:0] dq[$];
    int          error_cnt, samples_checked, cyc, k;
    logic [31:0] v;
    logic [7:0]  idx [8] = '{`IDX_GLOBAL_COMMAND, `IDX_TEST_FUNCTION, `IDX_WORD_ORDER_CONFIG,
        `IDX_PORT_PATH_ENABLE, `IDX_LEGACY_DATA_PATH, `IDX_LEGACY_DIRECTION, `IDX_LEGACY_EDGE,
        `IDX_IRQ_MASK};
    logic [31:0] msk [8] = '{32'h8, 32'h1, 32'h9, 32'hF, 32'hFF, 32'hFF, 32'hFF, 32'hF};
    logic [3:0]  cfg [4] = '{4'h0, 4'h1, 4'h8, 4'h9};

    dma_channel_control_regs #(.ORIGIN_CODE(8'hA5)) dut_u (.*); // Origin code arbitrary.
    dma_far_side #(.FRAMING(8'h3C)) far_u (.*);

    // ==================================================================
    // Clock, timeout and result checking.
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            end_sim();
        end
    end
    // Results are sampled at the falling edge.
    always @(negedge clk) begin
        if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, rq.size() ? rq.pop_front() : 'x);
        if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.size() ? rq.pop_front() : 'x);
        if (tx_out_valid !== 2'b00)
            chk({rx_out_valid, tx_out_word, rx_out_word}, dq.size() ? dq.pop_front() : 'x);
    end

    task automatic chk(input logic [129:0] got, input logic [129:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
            error_cnt++;
        end
    endtask : chk

    function automatic logic [31:0] sw(input logic [31:0] w, input logic [3:0] c);
        if (c[3]) w = {w[15:0], w[31:16]};
        if (c[0]) w = {w[23:16], w[31:24], w[7:0], w[15:8]};
        return w;
    endfunction : sw

    // One bus transfer; each channel drops at the edge that takes it, then one idle edge.
    task automatic bus(input bit w, input logic [7:0] i, input logic [31:0] d, input logic [33:0] e);
        rq.push_back(e);
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {i, 2'b00, i, 2'b00, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{!w}};
        do begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_bready && s_axi_bvalid) s_axi_bready <= 1'b0;
            if (s_axi_rready && s_axi_rvalid) s_axi_rready <= 1'b0;
        end while (s_axi_awvalid | s_axi_wvalid | s_axi_arvalid | s_axi_bready | s_axi_rready);
    endtask : bus

    task automatic wr(input logic [7:0] i, input logic [31:0] d, input logic [1:0] r = `AXI_RESP_OKAY);
        bus(1'b1, i, d, {r, 32'h0});
    endtask : wr

    task automatic rd(input logic [7:0] i, input logic [33:0] e);
        bus(1'b0, i, 32'h0, e);
    endtask : rd

    // Offers n random word pairs and notes their expected reorder.
    task automatic send(input int n, input logic [3:0] c, input logic [1:0] rv);
        logic [63:0] t, r;
        repeat (n) begin
            t = {$urandom, $urandom};
            r = {$urandom, $urandom};
            dq.push_back({rv, sw(t[63:32], c), sw(t[31:0], c), sw(r[63:32], c), sw(r[31:0], c)});
            {tx_in_valid, rx_in_valid, tx_in_word, rx_in_word} <= {4'hF, t, r};
            @(posedge clk);
        end
        {tx_in_valid, rx_in_valid} <= 4'h0;
        @(posedge clk);
    endtask : send

    task automatic end_sim();
        if (error_cnt == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    // ==================================================================
    // Main sequence.
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready, rst_n} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready, underrun, overrun} = '0;
        {tx_in_valid, tx_in_word, rx_in_valid, rx_in_word} = '0;
        s_axi_wstrb = 4'hF;
        void'($urandom(32'h58C3));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (k = 0; k < 8; k++) rd(idx[k], 34'h0);
        wr(`IDX_CLOCK_LOCK_STATUS, 32'hFF);
        rd(`IDX_CLOCK_LOCK_STATUS, 34'h0);
        wr(`IDX_CONFIG_ORIGIN_CODE, 32'h3);
        rd(`IDX_CONFIG_ORIGIN_CODE, 34'hA5);
        rd(`IDX_LEGACY_FRAMING, 34'h3C);
        rd(8'h07, {`AXI_RESP_SLVERR, 32'h0});
        wr(8'h07, 32'hFF, `AXI_RESP_SLVERR);
        for (k = 0; k < 8; k++) begin
            v = $urandom;
            wr(idx[k], v);
            rd(idx[k], {2'b00, v & msk[k]});
        end
        wr(`IDX_GLOBAL_COMMAND, 32'h8);
        wr(`IDX_PORT_PATH_ENABLE, 32'hF);
        repeat (20) @(posedge clk);
        rd(`IDX_CLOCK_LOCK_STATUS, 34'h1);
        for (k = 0; k < 4; k++) begin
            wr(`IDX_WORD_ORDER_CONFIG, {28'h0, cfg[k]});
            send(4, cfg[k], 2'b11);
        end
        wr(`IDX_IRQ_MASK, 32'h0);
        underrun <= 1'b1;
        repeat (4) @(posedge clk);
        underrun <= 1'b0;
        @(negedge clk);
        chk(irq, 1'b0);
        rd(`IDX_UNDERFLOW_FLAGS, 34'h3);
        wr(`IDX_IRQ_MASK, 32'hF);
        @(negedge clk);
        chk(irq, 1'b1);
        rd(`IDX_IRQ_STATUS, 34'h3);
        @(negedge clk);
        chk(irq, 1'b0);
        overrun <= 1'b1;
        send(2, 4'h9, 2'b00);
        overrun <= 1'b0;
        send(2, 4'h9, 2'b00);
        rd(`IDX_OVERFLOW_FLAGS, 34'h3);
        wr(`IDX_PORT_PATH_ENABLE, 32'h0);
        rd(`IDX_CLOCK_LOCK_STATUS, 34'h0);
        rd(`IDX_OVERFLOW_FLAGS, 34'h0);
        wr(`IDX_PORT_PATH_ENABLE, 32'hF);
        send(2, 4'h9, 2'b11);
        overrun <= 1'b1;
        send(1, 4'h9, 2'b00);
        overrun <= 1'b0;
        wr(`IDX_GLOBAL_COMMAND, 32'h0);
        rd(`IDX_OVERFLOW_FLAGS, 34'h0);
        wr(`IDX_GLOBAL_COMMAND, 32'h8);
        wr(`IDX_PORT_PATH_ENABLE, 32'h5);
        @(negedge clk);
        chk({pll_reset, fifo_flush, chan_reset}, 6'h0A);
        wr(`IDX_GLOBAL_COMMAND, 32'h0);
        @(negedge clk);
        chk({pll_reset, fifo_flush, chan_reset}, 6'h1F);
        wr(`IDX_PORT_PATH_ENABLE, 32'h0);
        @(negedge clk);
        chk({pll_reset, fifo_flush, chan_reset}, 6'h3F);
        chk(rq.size() + dq.size(), 0);
        end_sim();
    end
endmodule : tb_top

bind dma_channel_control_regs dma_ctrl_checker chk_u (.*);
